/* File: pkg/adc_seq_pkg.sv */
// package for the converter sequencer: register map, field layout, timing
// assumes a 32-bit apb slave with word-aligned registers
package adc_seq_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
  localparam logic [7:0] OFS_CONTROL_A    = 8'h04;
  localparam logic [7:0] OFS_CONTROL_B    = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW   = 8'h0C;
  localparam logic [7:0] OFS_RESULT_HIGH  = 8'h10;

  // ****************************************************
  // field positions
  // ****************************************************
  // input_select_register: [3:0] channel, [4] left adjust, [7:5] reference
  localparam int CHAN_LSB  = 0;
  localparam int LADJ_BIT  = 4;
  localparam int REF_LSB   = 5;
  // converter_control_a: [2:0] prescale, [3] done flag, [4] auto trigger,
  // [5] start, [6] enable
  localparam int PS_LSB    = 0;
  localparam int DONE_BIT  = 3;
  localparam int ATE_BIT   = 4;
  localparam int START_BIT = 5;
  localparam int EN_BIT    = 6;
  // converter_control_b: [2:0] trigger select
  localparam int TS_LSB    = 0;

  localparam logic [3:0] CHAN_TEMPERATURE = 4'hF;
  localparam logic [2:0] TS_FREE_RUN      = 3'h0;

  // ****************************************************
  // timing, in converter clock cycles (half cycles for sampling)
  // ****************************************************
  localparam int NORMAL_CYCLES  = 13;
  localparam int FIRST_CYCLES   = 25;
  localparam int NORMAL_SH_HALF = 3;
  localparam int FIRST_SH_HALF  = 27;
  localparam int AUTO_SH_HALF   = 4;

  typedef struct packed {
    logic [3:0] channel;
    logic [2:0] reference;
  } selection_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11
  } state_type;

endpackage

/* File: logic/sar_adc_sequencer.sv */
// sar_adc_sequencer: control of a 10-bit successive-approximation converter
// assumes an apb master on pclk and an analog core that answers sar_bit
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer #(
  parameter int TRIG_COUNT = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [TRIG_COUNT-1:0] trigger_sources,
  input  wire logic        sar_bit,
  output logic      [3:0]  channel_select,
  output logic      [2:0]  reference_select,
  output logic             analog_power,
  output logic             sample_hold,
  output logic      [9:0]  sar_trial
);

  if (TRIG_COUNT < 2 || TRIG_COUNT > 8) begin : bad_trig_count
    $error("TRIG_COUNT must be 2..8");
  end

  // ****************************************************
  // registers
  // ****************************************************
  logic [7:0] insel_q;
  logic [2:0] ps_q;
  logic       done_q;
  logic       ate_q;
  logic       start_q;
  logic       en_q;
  logic [2:0] ts_q;
  logic [9:0] result_q;
  logic       lock_q;
  logic       first_q;
  logic [7:0] presc_q;
  logic       trig_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       pend_q;
  adc_seq_pkg::state_type state_q;
  logic [5:0] half_q;
  logic       auto_q;
  logic [9:0] sar_q;
  logic [3:0] bit_q;
  adc_seq_pkg::selection_type sel_q;

  // ****************************************************
  // bus decode
  // ****************************************************
  wire acc     = psel && penable;
  wire wr      = acc && pwrite;
  wire rd      = acc && !pwrite;
  wire hit_is  = paddr == adc_seq_pkg::OFS_INPUT_SELECT;
  wire hit_a   = paddr == adc_seq_pkg::OFS_CONTROL_A;
  wire hit_b   = paddr == adc_seq_pkg::OFS_CONTROL_B;
  wire hit_lo  = paddr == adc_seq_pkg::OFS_RESULT_LOW;
  wire hit_hi  = paddr == adc_seq_pkg::OFS_RESULT_HIGH;
  wire mapped  = hit_is | hit_a | hit_b | hit_lo | hit_hi;
  wire wr_a    = wr && hit_a && clk_en;
  wire start_w = wr_a && pwdata[adc_seq_pkg::START_BIT];
  wire clr_done = wr_a && pwdata[adc_seq_pkg::DONE_BIT];
  wire rd_lo   = rd && hit_lo && clk_en;
  wire rd_hi   = rd && hit_hi && clk_en;

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  wire [7:0] res_lo = insel_q[adc_seq_pkg::LADJ_BIT] ?
                      {result_q[1:0], 6'h00} : result_q[7:0];
  wire [7:0] res_hi = insel_q[adc_seq_pkg::LADJ_BIT] ?
                      result_q[9:2] : {6'h00, result_q[9:8]};

  wire [7:0] reg_a = {1'b0, en_q, start_q, ate_q, done_q, ps_q};

  wire [7:0] rsel =
    hit_is ? insel_q :
    hit_a  ? reg_a :
    hit_b  ? {5'h00, ts_q} :
    hit_lo ? res_lo :
    hit_hi ? res_hi : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      prdata <= {24'h00_0000, rsel};
    end
  end

  // ****************************************************
  // prescaler
  // ****************************************************
  wire [7:0] presc_next = 8'(presc_q + 8'h01);
  // divide by 2^(ps+1), the converter clock toggles at bit ps
  wire half_tick = presc_next[ps_q] != presc_q[ps_q];
  wire adc_rise  = half_tick && !presc_next[ps_q];

  // ****************************************************
  // trigger
  // ****************************************************
  wire free_run = ts_q == adc_seq_pkg::TS_FREE_RUN;
  wire trig_lvl = int'(ts_q) < TRIG_COUNT && trigger_sources[ts_q];
  wire trig_edge = sync2_q && !trig_q;
  wire busy     = state_q != adc_seq_pkg::ST_IDLE;
  wire auto_go  = en_q && ate_q && !free_run && trig_edge && !busy;

  wire last_half = half_q == 6'(2 * (first_q ? adc_seq_pkg::FIRST_CYCLES
                                       : adc_seq_pkg::NORMAL_CYCLES) - 1);
  wire conv_end = state_q == adc_seq_pkg::ST_CONV && half_tick && last_half;
  wire [5:0] sh_n = auto_q ? 6'(adc_seq_pkg::AUTO_SH_HALF) :
                    first_q ? 6'(adc_seq_pkg::FIRST_SH_HALF) :
                    6'(adc_seq_pkg::NORMAL_SH_HALF);
  wire restart  = conv_end && ate_q && free_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 8'h00;
    end else if (clk_en) begin
      if (!en_q || auto_go) begin
        presc_q <= 8'h00;
      end else begin
        presc_q <= presc_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      trig_q  <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= trig_lvl;
      sync2_q <= sync1_q;
      trig_q  <= sync2_q;
    end
  end

  // ****************************************************
  // control registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insel_q <= 8'h00;
      ps_q    <= 3'h0;
      ate_q   <= 1'b0;
      en_q    <= 1'b0;
      ts_q    <= 3'h0;
    end else if (clk_en && wr) begin
      if (hit_is) begin
        insel_q <= pwdata[7:0];
      end
      if (hit_a) begin
        ps_q  <= pwdata[adc_seq_pkg::PS_LSB +: 3];
        ate_q <= pwdata[adc_seq_pkg::ATE_BIT];
        en_q  <= pwdata[adc_seq_pkg::EN_BIT];
      end
      if (hit_b) begin
        ts_q <= pwdata[adc_seq_pkg::TS_LSB +: 3];
      end
    end
  end

  // ****************************************************
  // conversion sequencer
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_seq_pkg::ST_IDLE;
      start_q <= 1'b0;
      half_q  <= 6'h00;
      auto_q  <= 1'b0;
      first_q <= 1'b1;
    end else if (clk_en) begin
      if (!en_q) begin
        state_q <= adc_seq_pkg::ST_IDLE;
        start_q <= 1'b0;
        first_q <= 1'b1;
      end else begin
        case (state_q)
          adc_seq_pkg::ST_IDLE: begin
            if (auto_go) begin
              state_q <= adc_seq_pkg::ST_CONV;
              start_q <= 1'b1;
              auto_q  <= 1'b1;
              half_q  <= 6'h00;
            end else if (start_w) begin
              state_q <= adc_seq_pkg::ST_WAIT;
              start_q <= 1'b1;
              auto_q  <= 1'b0;
            end
          end
          adc_seq_pkg::ST_WAIT: begin
            if (adc_rise) begin
              state_q <= adc_seq_pkg::ST_CONV;
              half_q  <= 6'h00;
            end
          end
          adc_seq_pkg::ST_CONV: begin
            if (half_tick) begin
              half_q <= 6'(half_q + 6'h01);
            end
            if (conv_end) begin
              first_q <= 1'b0;
              half_q  <= 6'h00;
              auto_q  <= 1'b0;
              if (restart) begin
                state_q <= adc_seq_pkg::ST_CONV;
              end else begin
                state_q <= adc_seq_pkg::ST_IDLE;
                start_q <= 1'b0;
              end
            end
          end
          default: begin
            state_q <= adc_seq_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // hold pulse at the chosen half cycle
  wire sh_now = state_q == adc_seq_pkg::ST_CONV && half_tick &&
                half_q == sh_n - 6'h01;
  wire sar_run = state_q == adc_seq_pkg::ST_CONV && adc_rise &&
                 half_q >= sh_n && bit_q != 4'h0;

  // one trial bit per converter clock after the hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q       <= 10'h000;
      bit_q       <= 4'h0;
      sample_hold <= 1'b0;
    end else if (clk_en) begin
      sample_hold <= sh_now;
      if (sh_now) begin
        sar_q <= 10'h200;
        bit_q <= 4'hA;
      end else if (sar_run) begin
        bit_q <= 4'(bit_q - 4'h1);
        if (!sar_bit) begin
          sar_q[bit_q - 4'h1] <= 1'b0;
        end
        if (bit_q > 4'h1) begin
          sar_q[bit_q - 4'h2] <= 1'b1;
        end
      end
    end
  end

  assign sar_trial = sar_q;

  // ****************************************************
  // result, lock, done flag
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= 10'h000;
      lock_q   <= 1'b0;
      done_q   <= 1'b0;
    end else if (clk_en) begin
      if (conv_end && !lock_q) begin
        result_q <= sar_q;
      end
      if (rd_lo) begin
        lock_q <= 1'b1;
      end else if (rd_hi) begin
        lock_q <= 1'b0;
      end
      if (conv_end) begin
        done_q <= 1'b1;
      end else if (clr_done) begin
        done_q <= 1'b0;
      end
    end
  end

  // ****************************************************
  // analog side selections
  // ****************************************************
  // track while idle, freeze during conversion, track in last cycle
  wire track = !busy || (state_q == adc_seq_pkg::ST_CONV &&
               half_q >= 6'(2 * (first_q ? adc_seq_pkg::FIRST_CYCLES
                               : adc_seq_pkg::NORMAL_CYCLES) - 2));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
    end else if (clk_en && track) begin
      sel_q.channel   <= insel_q[adc_seq_pkg::CHAN_LSB +: 4];
      sel_q.reference <= insel_q[adc_seq_pkg::REF_LSB +: 3];
    end
  end

  // the analog core decodes these codes, temperature at 4'hF
  assign channel_select   = en_q ? sel_q.channel : 4'h0;
  assign reference_select = en_q ? sel_q.reference : 3'h0;
  assign analog_power     = en_q;

  // ****************************************************
  // checks
  // ****************************************************
  AST_START_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    busy |-> start_q) else $error("start bit low during conversion");
  AST_DONE_SET: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_end |=> done_q) else $error("done flag not set");
  AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    lock_q |=> $stable(result_q)) else $error("result changed while locked");
  AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !en_q |=> presc_q == 8'h00) else $error("prescaler not held");
  AST_SINGLE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conv_end && !ate_q && en_q |=> !start_q)
    else $error("start bit not cleared");
  AST_FREE_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && restart && en_q |=> state_q == adc_seq_pkg::ST_CONV)
    else $error("free running did not restart");
  AST_NO_RETRIG: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && en_q && busy && trig_edge
    |=> presc_q == 8'($past(presc_q) + 8'h01))
    else $error("edge taken while busy");
  AST_AUTO_START: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && auto_go
    |=> state_q == adc_seq_pkg::ST_CONV && presc_q == 8'h00)
    else $error("trigger edge did not start");
  AST_SEL_FROZEN: assert property (@(posedge pclk) disable iff (!presetn)
    busy && !track |=> $stable(sel_q))
    else $error("selection moved in conversion");
  AST_WAIT_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == adc_seq_pkg::ST_WAIT && clk_en && en_q && !adc_rise
    |=> state_q == adc_seq_pkg::ST_WAIT) else $error("start before edge");
  COV_SINGLE: cover property (@(posedge pclk) start_w ##[1:200] conv_end);
  COV_AUTO: cover property (@(posedge pclk) auto_go);
  COV_LOST: cover property (@(posedge pclk) conv_end && lock_q);

endmodule

`default_nettype wire

/* File: testbench/analog_core_model.sv */
// analog core model: one input level per channel, comparator answer on sar_bit
// assumes the bench sets level[] before a conversion samples it
`timescale 1ns/1ps
`default_nettype none

module analog_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] channel_select,
  input  wire logic       analog_power,
  input  wire logic       sample_hold,
  input  wire logic [9:0] sar_trial,
  input  wire logic [9:0] level [16],
  output logic            sar_bit
);
  logic [9:0] held_q;
  logic [9:0] held_d;
  logic       junk_q;

  // ****************************************************
  // sample and hold, comparator
  // ****************************************************
  assign held_d = sample_hold ? level[channel_select] : held_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 10'h000;
      junk_q <= 1'b0;
    end else begin
      held_q <= held_d;
      junk_q <= ~junk_q;
    end
  end
  // unpowered core gives a changing pattern, not a stale answer
  assign sar_bit = analog_power ? (held_d >= sar_trial) : junk_q;
endmodule

`default_nettype wire

/* File: testbench/sar_adc_sequencer_tb.sv */
// self-checking bench for the converter sequencer
// assumes the analog core model on the far side and apb with zero waits
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_tb;
  localparam logic [7:0]  A_SEL = adc_seq_pkg::OFS_INPUT_SELECT;
  localparam logic [7:0]  A_CTL = adc_seq_pkg::OFS_CONTROL_A;
  localparam logic [7:0]  A_TRG = adc_seq_pkg::OFS_CONTROL_B;
  localparam logic [7:0]  A_LO  = adc_seq_pkg::OFS_RESULT_LOW;
  localparam logic [7:0]  A_HI  = adc_seq_pkg::OFS_RESULT_HIGH;
  localparam logic [31:0] EN    = 32'h1 << adc_seq_pkg::EN_BIT;
  localparam logic [31:0] START = 32'h1 << adc_seq_pkg::START_BIT;
  localparam logic [31:0] ATE   = 32'h1 << adc_seq_pkg::ATE_BIT;
  localparam logic [31:0] DONE  = 32'h1 << adc_seq_pkg::DONE_BIT;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic        sar_bit, analog_power, sample_hold;
  logic [7:0]  paddr, trigger_sources;
  logic [31:0] pwdata, prdata, rv, e, m;
  logic [3:0]  channel_select;
  logic [2:0]  reference_select, r3;
  logic [9:0]  sar_trial, v, w;
  logic [9:0]  level [16];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int          errors, checks, cyc, sh_cnt, sh_at, t0, s0;

  sar_adc_sequencer #(.TRIG_COUNT(8)) i_sar_adc_sequencer (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_sources(trigger_sources), .sar_bit(sar_bit),
    .channel_select(channel_select), .reference_select(reference_select),
    .analog_power(analog_power), .sample_hold(sample_hold),
    .sar_trial(sar_trial));
  analog_core_model i_analog_core_model (
    .pclk(pclk), .presetn(presetn), .channel_select(channel_select),
    .analog_power(analog_power), .sample_hold(sample_hold),
    .sar_trial(sar_trial), .level(level), .sar_bit(sar_bit));

  // ****************************************************
  // clock, cycle count, result monitor
  // ****************************************************
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sample_hold === 1'b1) begin
      sh_cnt <= sh_cnt + 1;
      sh_at  <= cyc;
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) chk("read data", e & m, prdata & m);
    end
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task chk(input string what, input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (y !== x) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, x, y);
    end
  endtask
  task apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] x, input logic [31:0] k);
    if (!wr_n) begin
      exp_q.push_back(x);
      msk_q.push_back(k);
    end
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_n;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    apb(1'b0, a, 32'h0, x, k);
  endtask
  task idle;
    do rd(A_CTL, 32'h0, 32'h0);
    while (rv[adc_seq_pkg::START_BIT] !== 1'b0 && cyc - t0 < 3000);
  endtask
  task conv(input logic [31:0] ctl, input int n, input int sh, input int dv);
    wr(A_CTL, ctl | START | DONE);
    t0 = cyc;
    rd(A_CTL, START, START);
    idle();
    chk("duration", 32'h1, 32'(cyc-t0 >= n*dv-2 && cyc-t0 <= n*dv+dv+6));
    chk("hold", 32'h1, 32'(sh_at-t0 >= sh*dv/2-2 && sh_at-t0 <= sh*dv/2+dv+2));
    rd(A_CTL, DONE, DONE);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, trigger_sources} = '0;
    for (int i = 0; i < 16; i++) level[i] = 10'h000;
    void'($urandom(32'h4427A290));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTL, 32'h0, 32'hFFFFFFFF);
    rd(A_SEL, 32'h0, 32'hFFFFFFFF);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    chk("slave error", 32'h1, 32'(slv));
    $display("test reset done");
    r3 = 3'($urandom);
    wr(A_SEL, {24'h0, r3, 5'h02});
    chk("channel off", 32'h0, 32'(channel_select));
    wr(A_CTL, EN);
    chk("channel", 32'h2, 32'(channel_select));
    chk("reference", 32'(r3), 32'(reference_select));
    v = 10'($urandom);
    level[2] = v;
    conv(EN, adc_seq_pkg::FIRST_CYCLES, adc_seq_pkg::FIRST_SH_HALF, 2);
    rd(A_LO, 32'(v[7:0]), 32'hFF);
    rd(A_HI, 32'(v[9:8]), 32'hFF);
    wr(A_SEL, {24'h0, r3, 5'h12});
    v = 10'($urandom);
    level[2] = v;
    conv(EN, adc_seq_pkg::NORMAL_CYCLES, adc_seq_pkg::NORMAL_SH_HALF, 2);
    rd(A_LO, {24'h0, v[1:0], 6'h00}, 32'hFF);
    rd(A_HI, 32'(v[9:2]), 32'hFF);
    $display("test conversions done");
    rd(A_LO, {24'h0, v[1:0], 6'h00}, 32'hFF);
    w = ~v;
    level[2] = w;
    conv(EN, adc_seq_pkg::NORMAL_CYCLES, adc_seq_pkg::NORMAL_SH_HALF, 2);
    rd(A_HI, 32'(v[9:2]), 32'hFF);
    rd(A_LO, {24'h0, v[1:0], 6'h00}, 32'hFF);
    rd(A_HI, 32'(v[9:2]), 32'hFF);
    $display("test lock done");
    wr(A_SEL, 32'h0F);
    v = 10'($urandom);
    level[15] = v;
    wr(A_CTL, EN | START | DONE);
    t0 = cyc;
    wr(A_SEL, 32'h01);
    chk("channel held", 32'hF, 32'(channel_select));
    idle();
    chk("channel new", 32'h1, 32'(channel_select));
    rd(A_LO, 32'(v[7:0]), 32'hFF);
    rd(A_HI, 32'(v[9:8]), 32'hFF);
    $display("test channel done");
    wr(A_TRG, 32'h1);
    wr(A_CTL, EN | ATE | DONE);
    s0 = sh_cnt;
    t0 = cyc;
    trigger_sources <= 8'h02;
    repeat (10) @(posedge pclk);
    trigger_sources <= 8'h00;
    repeat (2) @(posedge pclk);
    trigger_sources <= 8'h02;
    repeat (100) @(posedge pclk);
    chk("auto count", 32'h1, 32'(sh_cnt - s0));
    chk("auto hold", 32'h1, 32'(sh_at - t0 >= 5 && sh_at - t0 <= 10));
    rd(A_CTL, DONE, DONE);
    wr(A_CTL, EN | DONE);
    trigger_sources <= 8'h00;
    wr(A_TRG, 32'(adc_seq_pkg::TS_FREE_RUN));
    wr(A_CTL, EN | ATE | START);
    s0 = sh_cnt;
    repeat (100) @(posedge pclk);
    chk("free run", 32'h1, 32'(sh_cnt - s0 >= 3 && sh_cnt - s0 <= 4));
    rd(A_CTL, START, START);
    $display("test trigger done");
    wr(A_CTL, 32'h0);
    chk("power off", 32'h0, 32'({analog_power, channel_select}));
    wr(A_CTL, EN | 32'h1);
    conv(EN | 32'h1, adc_seq_pkg::FIRST_CYCLES, adc_seq_pkg::FIRST_SH_HALF, 4);
    $display("test prescaler done");
    report_and_stop();
  end
endmodule

`default_nettype wire
